// ---- hdl/rsb_pkg.sv ----
// Package with timing constants and state encodings for the reset supervisor.
package rsb_pkg;
    localparam int unsigned RSB_CLK_MHZ = 100;
    localparam int unsigned RSB_MR_MIN_LOW_NS = 1000;
    localparam int unsigned RSB_MR_GLITCH_NS = 100;
    localparam int unsigned RSB_MR_LOW_CYCLES = (RSB_MR_MIN_LOW_NS * RSB_CLK_MHZ) / 1000;
    localparam int unsigned RSB_MR_GLITCH_CYCLES = (RSB_MR_GLITCH_NS * RSB_CLK_MHZ + 999) / 1000;
    localparam int unsigned RSB_GLITCH_US = 60;
    localparam int unsigned RSB_GLITCH_CYCLES = RSB_GLITCH_US * RSB_CLK_MHZ;
    localparam int unsigned RSB_HOLD_MS = 200;
    localparam int unsigned RSB_HOLD_CYCLES = RSB_HOLD_MS * 1000 * RSB_CLK_MHZ;
    localparam int unsigned RSB_CNT_W = 25;
    localparam logic RSB_RESET_ACTIVE = 1'b1;

    typedef enum logic [1:0] {
        RSB_ST_POR = 2'b00,
        RSB_ST_HOLD = 2'b01,
        RSB_ST_RUN = 2'b10
    } rsb_state_t;
endpackage : rsb_pkg

// ---- hdl/rsb_if.sv ----
// Interface carrying the manual reset filter signals between the two modules.
`timescale 1ns/100ps
`default_nettype none
interface rsb_filt_if;
    logic sample_n;
    logic gate;
    logic pressed;
    modport filter (input sample_n, input gate, output pressed);
    modport user (output sample_n, output gate, input pressed);
endinterface : rsb_filt_if
`default_nettype wire

// ---- hdl/rsb_debounce.sv ----
// Low-level filter with a minimum qualifying time.
`timescale 1ns/100ps
`default_nettype none
module rsb_debounce
    import rsb_pkg::*;
#(
    parameter int unsigned LOW_CYCLES = RSB_MR_LOW_CYCLES,
    parameter int unsigned CNT_W = 12
) (
    input wire logic clk_in,
    input wire logic reset_in,
    rsb_filt_if.filter f
);
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W-1:0] low_cnt_d;
    wire logic counting = f.gate && !f.sample_n;
    wire logic reached = (low_cnt_q >= CNT_W'(LOW_CYCLES));

    // Any high sample restarts the count, so short low pulses never qualify.
    assign low_cnt_d = !counting ? '0 : (reached ? low_cnt_q : low_cnt_q + CNT_W'(1));
    assign f.pressed = counting && reached; // R4

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            low_cnt_q <= '0;
        end else begin
            low_cnt_q <= low_cnt_d;
        end
    end

    chk_short_low_ignored: assert property (@(posedge clk_in) disable iff (reset_in) // R4
        $rose(f.pressed) |-> $past(counting, 2) && $past(counting, 8))
        else $error("Manual reset qualified too early.");
endmodule : rsb_debounce
`default_nettype wire

// ---- hdl/rsb_supervisor.sv ----
// Reset supervisor with manual reset, supply monitor and backup switchover.
// Contract
// R1 - Hold everything in its power-on state until the switched supply first rises; code still passes buzzer_drive_in to the buzzer output.
// R2 - Flag loss of retention when the switched supply drops too low.
// R3 - Reset asserted while manual reset is low, then one full timeout after.
// R4 - Ignore short manual reset lows; host holds it low at least one microsecond.
// R5 - While reset is active, ignore manual reset, watchdog, chip select and serial bus.
// R6 - Both resets active while main supply is below trip level.
// R7 - After supply recovers, hold resets for the timeout, then release both.
// R8 - A brownout reasserts both reset outputs immediately.
// R9 - Every reset assertion lasts at least one full timeout period.
// R10 - Trip thresholds belong to the analog comparator feeding below-trip.
// R11 - Reject short supply dips below the trip level without a reset.
// R12 - Below trip and below backup: switch output supply to backup, assert indicator.
// R13 - Above backup or trip: reconnect main supply, release the indicator.
// R14 - In backup, open-drain reset driven low and push-pull reset high; code drives the open-drain low only while out_above_min_in is high.
// R15 - In backup, power-fail stays active, buzzer floats, gated chip select pulled up.
// R16 - Timeout and glitch window are parameterised counters.
// R17 - Comparators arrive as synchronised below-trip and below-backup inputs.
`timescale 1ns/100ps
`default_nettype none
module rsb_supervisor
    import rsb_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = RSB_HOLD_CYCLES,
    parameter int unsigned GLITCH_CYCLES = RSB_GLITCH_CYCLES,
    parameter int unsigned CNT_W = RSB_CNT_W
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic out_above_por_in,
    input wire logic out_above_retain_in,
    input wire logic out_above_min_in,
    input wire logic main_below_trip_in,
    input wire logic main_below_backup_in,
    input wire logic manual_reset_n_in,
    input wire logic watchdog_kick_in,
    input wire logic chip_select_n_in,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic powerfail_sense_in,
    input wire logic buzzer_drive_in,
    output logic reset_n_out,
    output logic reset_n_oe_out,
    output logic reset_out,
    output logic backup_active_n_out,
    output logic backup_active_n_oe_out,
    output logic use_backup_out,
    output logic regs_released_out,
    output logic retention_lost_out,
    output logic powerfail_flag_n_out,
    output logic buzzer_out,
    output logic buzzer_oe_out,
    output logic chip_select_n_out,
    output logic watchdog_kick_out,
    output logic serial_clock_out,
    output logic serial_data_out
);
    // Two-stage synchronisers, one per pin except power-fail sense and buzzer drive, in a single vector.
    localparam int unsigned NSYNC = 10;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    assign pin_raw = {out_above_por_in, out_above_retain_in, out_above_min_in, main_below_trip_in,
                      main_below_backup_in, manual_reset_n_in, watchdog_kick_in, chip_select_n_in,
                      serial_clock_in, serial_data_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= pin_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    wire logic s_por_ok = sync_q[9];
    wire logic s_retain_ok = sync_q[8];
    wire logic s_min_ok = sync_q[7];
    wire logic s_below_trip = sync_q[6]; // R17 R10
    wire logic s_below_backup = sync_q[5]; // R17
    wire logic s_mr_n = sync_q[4];
    wire logic s_wdi = sync_q[3];
    wire logic s_cs_n = sync_q[2];
    wire logic s_scl = sync_q[1];
    wire logic s_sda = sync_q[0];

    // Power-on release is sticky; later dips are covered by the retention flag.
    logic released_q;
    logic retain_lost_q;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            released_q <= 1'b0;
            retain_lost_q <= 1'b0;
        end else begin
            if (s_por_ok) begin
                released_q <= 1'b1; // R1
            end
            if (released_q && !s_retain_ok) begin
                retain_lost_q <= 1'b1; // R2
            end
        end
    end

    // Glitch filter: a dip must last the whole window to count as undervoltage.
    logic [CNT_W-1:0] dip_cnt_q;
    logic [CNT_W-1:0] dip_cnt_d;
    wire logic dip_full = (dip_cnt_q >= CNT_W'(GLITCH_CYCLES));
    wire logic under_volt = s_below_trip && dip_full; // R11 R16
    assign dip_cnt_d = !s_below_trip ? '0 : (dip_full ? dip_cnt_q : dip_cnt_q + CNT_W'(1));

    // Backup switch follows the raw comparators so the supply swaps without delay.
    wire logic on_backup = s_below_trip && s_below_backup; // R12 R13

    // Manual reset filter, gated off while reset is already active.
    logic rst_active;
    rsb_filt_if mr_if ();
    assign mr_if.sample_n = s_mr_n;
    assign mr_if.gate = !rst_active; // R5
    rsb_debounce #(
        .LOW_CYCLES(RSB_MR_LOW_CYCLES),
        .CNT_W(12)
    ) rsb_debounce_i (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .f(mr_if.filter)
    );

    // A press that started outside reset keeps reset held until the pin returns high.
    logic mr_held_q;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mr_held_q <= 1'b0;
        end else if (mr_if.pressed) begin
            mr_held_q <= 1'b1;
        end else if (s_mr_n) begin
            mr_held_q <= 1'b0;
        end
    end
    wire logic mr_cause = mr_if.pressed || (mr_held_q && !s_mr_n); // R3

    // Backup counts as a cause, so that a short dip into backup still costs a full timeout.
    wire logic cause = !released_q || under_volt || mr_cause || on_backup; // R6 R8 R14

    // Reset timing state machine.
    rsb_state_t state_q;
    rsb_state_t state_d;
    logic [CNT_W-1:0] hold_cnt_q;
    logic [CNT_W-1:0] hold_cnt_d;
    wire logic hold_done = (hold_cnt_q >= CNT_W'(HOLD_CYCLES - 1));

    always_comb begin
        state_d = state_q;
        hold_cnt_d = hold_cnt_q;
        case (state_q)
            RSB_ST_POR: begin
                hold_cnt_d = '0;
                if (!cause) begin
                    state_d = RSB_ST_HOLD;
                end
            end
            RSB_ST_HOLD: begin
                if (cause) begin
                    hold_cnt_d = '0; // R9
                    state_d = RSB_ST_POR;
                end else if (hold_done) begin
                    state_d = RSB_ST_RUN; // R7
                end else begin
                    hold_cnt_d = hold_cnt_q + CNT_W'(1);
                end
            end
            RSB_ST_RUN: begin
                hold_cnt_d = '0;
                if (cause) begin
                    state_d = RSB_ST_POR; // R8
                end
            end
            default: begin
                state_d = RSB_ST_POR;
                hold_cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= RSB_ST_POR;
            hold_cnt_q <= '0;
            dip_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            hold_cnt_q <= hold_cnt_d;
            dip_cnt_q <= dip_cnt_d;
        end
    end

    // Reset stays asserted in backup even if the counter logic were idle.
    assign rst_active = (state_q != RSB_ST_RUN) || on_backup; // R14

    // Registered outputs.
    logic rst_q;
    logic backup_supply_q;
    logic pfo_n_q;
    logic buz_q;
    logic cs_n_q;
    logic wdi_q;
    logic scl_q;
    logic sda_q;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rst_q <= RSB_RESET_ACTIVE;
            backup_supply_q <= 1'b0;
            pfo_n_q <= 1'b0;
            buz_q <= 1'b0;
            cs_n_q <= 1'b1;
            wdi_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            rst_q <= rst_active; // R6 R7 R14
            backup_supply_q <= on_backup; // R12 R13
            // Power-fail low while main is below trip, high while reset is active, else follows the sense pin.
            pfo_n_q <= s_below_trip ? 1'b0 : (rst_active ? 1'b1 : powerfail_sense_in); // R15
            buz_q <= buzzer_drive_in;
            // Inputs are blocked while reset is active; select and serial forced high, kick held.
            cs_n_q <= rst_active ? 1'b1 : s_cs_n; // R5 R15
            wdi_q <= rst_active ? wdi_q : s_wdi; // R5
            scl_q <= rst_active ? 1'b1 : s_scl; // R5
            sda_q <= rst_active ? 1'b1 : s_sda; // R5
        end
    end

    assign reset_n_out = 1'b0;
    assign reset_n_oe_out = rst_q && s_min_ok; // R14
    assign reset_out = rst_q; // R14
    assign backup_active_n_out = 1'b0;
    assign backup_active_n_oe_out = backup_supply_q; // R12
    assign use_backup_out = backup_supply_q;
    assign regs_released_out = released_q;
    assign retention_lost_out = retain_lost_q;
    assign powerfail_flag_n_out = pfo_n_q;
    assign buzzer_out = buz_q;
    assign buzzer_oe_out = !backup_supply_q; // R15
    assign chip_select_n_out = cs_n_q;
    assign watchdog_kick_out = wdi_q;
    assign serial_clock_out = scl_q;
    assign serial_data_out = sda_q;

    chk_backup_holds_reset: assert property (@(posedge clk_in) disable iff (reset_in) // R14
        backup_supply_q |-> reset_out && !buzzer_oe_out)
        else $error("Backup without reset or with buzzer driven.");
    chk_brownout_reasserts: assert property (@(posedge clk_in) disable iff (reset_in) // R8
        under_volt |=> ##1 reset_out)
        else $error("Brownout did not reassert reset.");
    chk_release_after_hold: assert property (@(posedge clk_in) disable iff (reset_in) // R9
        $fell(reset_out) |-> $past(state_q == RSB_ST_HOLD, 2) && $past(hold_done, 2) && !$past(cause, 2))
        else $error("Reset released early.");
    chk_mr_keeps_reset: assert property (@(posedge clk_in) disable iff (reset_in) // R3
        mr_cause |=> ##1 reset_out)
        else $error("Manual reset not held.");
    chk_gate_during_reset: assert property (@(posedge clk_in) disable iff (reset_in) // R5
        $past(rst_active) |-> chip_select_n_out && serial_clock_out)
        else $error("Input passed during reset.");
    chk_backup_indicator: assert property (@(posedge clk_in) disable iff (reset_in) // R12
        on_backup |=> backup_active_n_oe_out)
        else $error("Backup indicator missing.");
    chk_main_reconnect: assert property (@(posedge clk_in) disable iff (reset_in) // R13
        !s_below_trip |=> !use_backup_out)
        else $error("Main supply not reconnected.");
    chk_glitch_rejected: assert property (@(posedge clk_in) disable iff (reset_in) // R11
        $rose(under_volt) |-> $past(s_below_trip) && $past(dip_cnt_q) == CNT_W'(GLITCH_CYCLES - 1))
        else $error("Short dip caused reset.");
    chk_por_hold: assert property (@(posedge clk_in) disable iff (reset_in) // R1
        !released_q |=> ##1 reset_out)
        else $error("Reset released before power-on.");
    chk_retention_flag: assert property (@(posedge clk_in) disable iff (reset_in) // R2
        released_q && !s_retain_ok |=> retention_lost_out)
        else $error("Retention loss not flagged.");
    chk_backup_side_outputs: assert property (@(posedge clk_in) disable iff (reset_in) // R15
        backup_supply_q |-> !powerfail_flag_n_out && chip_select_n_out)
        else $error("Power-fail or chip select wrong in backup.");
    chk_hold_length: assert property (@(posedge clk_in) disable iff (reset_in) // R9
        state_q == RSB_ST_HOLD && state_d == RSB_ST_RUN |-> hold_cnt_q == CNT_W'(HOLD_CYCLES - 1))
        else $error("Timeout ended before its full count.");
    chk_por_state: assert property (@(posedge clk_in) disable iff (reset_in) // R1
        !released_q |-> state_q == RSB_ST_POR)
        else $error("State left power-on before release.");
    chk_kick_frozen: assert property (@(posedge clk_in) disable iff (reset_in) // R5
        $past(rst_active) |-> $stable(watchdog_kick_out))
        else $error("Watchdog kick passed during reset.");
    chk_indicator_release: assert property (@(posedge clk_in) disable iff (reset_in) // R13
        !on_backup |=> !backup_active_n_oe_out)
        else $error("Backup indicator stuck.");
    chk_undervolt_drives: assert property (@(posedge clk_in) disable iff (reset_in) // R6
        under_volt |=> ##1 reset_out && (reset_n_oe_out || !s_min_ok))
        else $error("Undervoltage without both resets.");
endmodule : rsb_supervisor
`default_nettype wire

// ---- bench/rsb_host_model.sv ----
// Host processor model: manual reset button, chip select, watchdog kick and serial lines.
`timescale 1ns/100ps
`default_nettype none
module rsb_host_model (
    input wire logic clk_in,
    input wire logic reset_line_in,
    output logic manual_reset_n_out,
    output logic chip_select_n_out,
    output logic watchdog_kick_out,
    output logic serial_clock_out,
    output logic serial_data_out
);
    initial begin
        manual_reset_n_out = 1'b1;
        chip_select_n_out = 1'b1;
        watchdog_kick_out = 1'b0;
        serial_clock_out = 1'b1;
        serial_data_out = 1'b1;
    end
    // The host keeps kicking even in reset, so a kick that leaks through is seen at once.
    always @(negedge clk_in) begin
        watchdog_kick_out <= ~watchdog_kick_out;
        serial_clock_out <= ~serial_clock_out;
    end
    // A hold of 101 cycles or more meets the minimum low time; shorter ones test the filter.
    task automatic press(input int cycles);
        @(negedge clk_in);
        manual_reset_n_out <= 1'b0;
        repeat (cycles) @(negedge clk_in);
        manual_reset_n_out <= 1'b1;
    endtask : press
    // A host held in reset cannot drive its select line, so it waits for the line to rise.
    task automatic select(input logic level);
        wait (reset_line_in === 1'b1);
        @(negedge clk_in);
        chip_select_n_out <= level;
        serial_data_out <= level;
    endtask : select
endmodule : rsb_host_model
`default_nettype wire

// ---- bench/rsb_supervisor_tb_top.sv ----
// Self-checking testbench for the reset supervisor.
`timescale 1ns/100ps
`default_nettype none
module rsb_supervisor_tb_top;
    import rsb_pkg::*;
    localparam int unsigned HOLD = 50;
    localparam int unsigned GLITCH = 10;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic out_above_por_in = 1'b0;
    logic out_above_retain_in = 1'b1;
    logic out_above_min_in = 1'b1;
    logic main_below_trip_in = 1'b0;
    logic main_below_backup_in = 1'b0;
    logic powerfail_sense_in = 1'b1;
    logic buzzer_drive_in = 1'b0;
    logic manual_reset_n_in, watchdog_kick_in, chip_select_n_in, serial_clock_in, serial_data_in;
    logic reset_n_out, reset_n_oe_out, reset_out, backup_active_n_out, backup_active_n_oe_out;
    logic use_backup_out, regs_released_out, retention_lost_out, powerfail_flag_n_out;
    logic buzzer_out, buzzer_oe_out, chip_select_n_out, watchdog_kick_out, serial_clock_out, serial_data_out;
    logic reset_line;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    logic w0;

    // Open-drain reset with a pull-up on the board.
    assign reset_line = reset_n_oe_out ? reset_n_out : 1'b1;
    always #5 clk_in = ~clk_in;

    rsb_supervisor #(.HOLD_CYCLES(HOLD), .GLITCH_CYCLES(GLITCH)) rsb_supervisor_i (
        .clk_in, .reset_in, .out_above_por_in, .out_above_retain_in, .out_above_min_in,
        .main_below_trip_in, .main_below_backup_in, .manual_reset_n_in, .watchdog_kick_in,
        .chip_select_n_in, .serial_clock_in, .serial_data_in, .powerfail_sense_in, .buzzer_drive_in,
        .reset_n_out, .reset_n_oe_out, .reset_out, .backup_active_n_out, .backup_active_n_oe_out,
        .use_backup_out, .regs_released_out, .retention_lost_out, .powerfail_flag_n_out,
        .buzzer_out, .buzzer_oe_out, .chip_select_n_out, .watchdog_kick_out, .serial_clock_out,
        .serial_data_out);

    rsb_host_model rsb_host_model_i (
        .clk_in(clk_in), .reset_line_in(reset_line), .manual_reset_n_out(manual_reset_n_in),
        .chip_select_n_out(chip_select_n_in), .watchdog_kick_out(watchdog_kick_in),
        .serial_clock_out(serial_clock_in), .serial_data_out(serial_data_in));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : chk_rng

    // Counts cycles until reset drops, bounded so a stuck reset cannot hang the run.
    task automatic count_release(output int cnt);
        cnt = 0;
        while (reset_out === 1'b1 && cnt < 400) begin
            @(negedge clk_in);
            cnt++;
        end
    endtask : count_release

    task automatic test_power_up();
        repeat (5) @(negedge clk_in);
        chk("reset in reset", 1'b1, reset_out);
        reset_in = 1'b0;
        out_above_por_in = 1'b1;
        count_release(n);
        chk_rng("power-up hold", HOLD, HOLD + 10, n);
        chk("regs released", 1'b1, regs_released_out);
        chk("drain released", 1'b0, reset_n_oe_out);
        buzzer_drive_in = 1'b1;
        @(negedge clk_in);
        chk("buzzer follows", 1'b1, buzzer_out);
        $display("test power_up done");
    endtask : test_power_up

    task automatic test_manual();
        rsb_host_model_i.select(1'b0);
        repeat (4) @(negedge clk_in);
        chk("select passes", 1'b0, chip_select_n_out);
        w0 = watchdog_kick_out;
        @(negedge clk_in);
        chk("kick passes", !w0, watchdog_kick_out);
        rsb_host_model_i.press(5);
        repeat (20) @(negedge clk_in);
        chk("short press ignored", 1'b0, reset_out);
        fork
            rsb_host_model_i.press(150);
            begin
                repeat (140) @(negedge clk_in);
                chk("reset while low", 1'b1, reset_out);
                chk("drain while low", 1'b1, reset_n_oe_out);
                chk("select gated", 1'b1, chip_select_n_out);
                chk("serial gated", 1'b1, serial_data_out);
                chk("clock gated", 1'b1, serial_clock_out);
                w0 = watchdog_kick_out;
                @(negedge clk_in);
                chk("kick frozen", w0, watchdog_kick_out);
            end
        join
        count_release(n);
        chk_rng("manual hold", HOLD, HOLD + 10, n);
        rsb_host_model_i.select(1'b1);
        $display("test manual done");
    endtask : test_manual

    task automatic test_brownout();
        main_below_trip_in = 1'b1;
        repeat (GLITCH - 5) @(negedge clk_in);
        main_below_trip_in = 1'b0;
        repeat (20) @(negedge clk_in);
        chk("glitch rejected", 1'b0, reset_out);
        main_below_trip_in = 1'b1;
        repeat (GLITCH + 15) @(negedge clk_in);
        chk("brownout reset", 1'b1, reset_out);
        chk("brownout drain", 1'b1, reset_n_oe_out);
        chk("brownout pfo", 1'b0, powerfail_flag_n_out);
        chk("main supply kept", 1'b0, use_backup_out);
        main_below_trip_in = 1'b0;
        count_release(n);
        chk_rng("brownout hold", HOLD, HOLD + 10, n);
        $display("test brownout done");
    endtask : test_brownout

    task automatic test_backup();
        main_below_trip_in = 1'b1;
        main_below_backup_in = 1'b1;
        repeat (GLITCH + 20) @(negedge clk_in);
        chk("on backup", 1'b1, use_backup_out);
        chk("indicator on", 1'b1, backup_active_n_oe_out);
        chk("indicator low", 1'b0, backup_active_n_out);
        chk("reset high", 1'b1, reset_out);
        chk("drain low", 1'b1, reset_n_oe_out);
        chk("drain data", 1'b0, reset_n_out);
        chk("buzzer floats", 1'b0, buzzer_oe_out);
        chk("pfo active", 1'b0, powerfail_flag_n_out);
        chk("select pulled up", 1'b1, chip_select_n_out);
        out_above_min_in = 1'b0;
        repeat (4) @(negedge clk_in);
        chk("drain below minimum", 1'b0, reset_n_oe_out);
        out_above_min_in = 1'b1;
        repeat (4) @(negedge clk_in);
        main_below_backup_in = 1'b0;
        repeat (6) @(negedge clk_in);
        chk("back on main", 1'b0, use_backup_out);
        chk("indicator off", 1'b0, backup_active_n_oe_out);
        chk("buzzer drives", 1'b1, buzzer_oe_out);
        main_below_trip_in = 1'b0;
        count_release(n);
        chk_rng("backup hold", HOLD, HOLD + 10, n);
        $display("test backup done");
    endtask : test_backup

    task automatic test_retention();
        chk("retention kept", 1'b0, retention_lost_out);
        out_above_retain_in = 1'b0;
        repeat (6) @(negedge clk_in);
        out_above_retain_in = 1'b1;
        repeat (6) @(negedge clk_in);
        chk("retention lost", 1'b1, retention_lost_out);
        $display("test retention done");
    endtask : test_retention

    // The whole sequence needs about 520 cycles; the ceiling leaves wide margin.
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        test_power_up();
        test_manual();
        test_brownout();
        test_backup();
        test_retention();
        end_sim();
    end
endmodule : rsb_supervisor_tb_top
`default_nettype wire
